// ### src/hbw_unit.sv
// Purpose: hardware breakpoint and watchpoint unit of one tile
// Assumes: status and config accesses and core events are on clk
// Notes: debug mode is entered by the core on debug_irq
// Overview of operation
// - data watch loads event info with address
// - resource watch loads event info with id
// - stop mask holds set threads outside debug
// - stopped threads stay halted after debug return
// - eight scratch words shared by two views
// - four instruction breakpoints compare PC
// - bit0 enables, bit1 selects equal/unequal
// - per-thread enable field, resets zero
// - four data watchpoints, two addresses each
// - control bit2 permits triggering on loads
// - bit1 picks AND or OR of conditions
// - control bit0 enables, resets zero
// - four resource watches with mask and value
// - bit1 picks condition, bit0 enables
// - tile config reachable by config transactions
// - cause code 3, 4 or 5
// - lowest-numbered trigger of the first hit class is reported
`timescale 1ns/1ps
`default_nettype none
module hbw_unit
  import hbw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ps_wr,
  input wire logic ps_rd,
  input wire logic [7:0] ps_num,
  input wire logic [31:0] ps_wdata,
  output logic [31:0] ps_rdata,
  input wire logic tc_wr,
  input wire logic tc_rd,
  input wire logic [7:0] tc_num,
  input wire logic [31:0] tc_wdata,
  output logic [31:0] tc_rdata,
  input wire logic debug_mode,
  input wire logic pc_valid,
  input wire logic [2:0] pc_thread,
  input wire logic [31:0] pc,
  input wire logic mem_valid,
  input wire logic mem_load,
  input wire logic [2:0] mem_thread,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [2:0] res_thread,
  input wire logic [31:0] res_id,
  output logic debug_irq,
  output logic [7:0] thread_hold
);
  // ***********************
  // register storage
  // ***********************
  logic [31:0] instr_break_address_r [HBW_NBP];
  logic [31:0] instr_break_ctrl_r [HBW_NBP];
  logic [31:0] data_watch_addr_first_r [HBW_NBP];
  logic [31:0] data_watch_addr_second_r [HBW_NBP];
  logic [31:0] data_watch_ctrl_r [HBW_NBP];
  logic [31:0] resource_watch_mask_r [HBW_NBP];
  logic [31:0] resource_watch_value_r [HBW_NBP];
  logic [31:0] resource_watch_ctrl_r [HBW_NBP];
  logic [31:0] debug_event_info_r;
  logic [31:0] event_type_r;
  logic [7:0] thread_stop_mask_r;
  logic [HBW_NBP-1:0] ib_hit, dw_hit, rw_hit;
  logic [7:0] pc_oh, mem_oh, res_oh;
  logic [1:0] sel_num;
  logic [2:0] sel_cause;
  logic [7:0] sel_thr;
  logic [31:0] sel_info;
  logic any_hit;
  logic [31:0] type_nxt;
  logic [31:0] info_nxt;
  logic [31:0] ps_rdata_nxt;
  logic [31:0] tc_rdata_nxt;
  logic [5:0] ps_grp;
  logic [1:0] ps_sub;
  hbw_scr_if scr();

  assign pc_oh = 8'(1) << pc_thread;
  assign mem_oh = 8'(1) << mem_thread;
  assign res_oh = 8'(1) << res_thread;
  assign ps_sub = ps_num[1:0];
  assign ps_grp = ps_num[7:2];

  // ***********************
  // scratch words
  // ***********************
  assign scr.ps_we = ps_wr && ps_num[7:3] == HBW_PS_SCR[7:3];
  assign scr.ps_idx = ps_num[2:0];
  assign scr.ps_wdata = ps_wdata;
  assign scr.tc_we = tc_wr && tc_num[7:3] == HBW_TC_SCR[7:3];
  assign scr.tc_idx = tc_num[2:0];
  assign scr.tc_wdata = tc_wdata;

  hbw_scratch u_scr (
    .clk(clk),
    .srst(srst),
    .s(scr.owner)
  );

  // ***********************
  // match units
  // ***********************
  genvar g;
  generate
    for (g = 0; g < HBW_NBP; g++) begin : gm
      hbw_match u_m (
        .ib_addr(instr_break_address_r[g]),
        .ib_ctrl(instr_break_ctrl_r[g]),
        .dw_a1(data_watch_addr_first_r[g]),
        .dw_a2(data_watch_addr_second_r[g]),
        .dw_ctrl(data_watch_ctrl_r[g]),
        .rw_mask(resource_watch_mask_r[g]),
        .rw_val(resource_watch_value_r[g]),
        .rw_ctrl(resource_watch_ctrl_r[g]),
        .ib_thr(pc_oh),
        .dw_thr(mem_oh),
        .rw_thr(res_oh),
        .pc_valid(pc_valid && !debug_mode),
        .pc(pc),
        .mem_valid(mem_valid && !debug_mode),
        .mem_load(mem_load),
        .mem_addr(mem_addr),
        .res_valid(res_valid && !debug_mode),
        .res_id(res_id),
        .ib_hit(ib_hit[g]),
        .dw_hit(dw_hit[g]),
        .rw_hit(rw_hit[g])
      );
    end
  endgenerate

  // ***********************
  // trigger priority
  // ***********************
  // instruction first, then data, then resource; lowest index in each
  always_comb begin
    sel_num = '0;
    sel_cause = HBW_CAUSE_IBP;
    sel_thr = 8'(pc_thread);
    sel_info = debug_event_info_r;
    any_hit = 1'b1;
    if (|ib_hit) begin
      sel_cause = HBW_CAUSE_IBP;
      sel_thr = 8'(pc_thread);
      for (int i = HBW_NBP - 1; i >= 0; i--) begin
        if (ib_hit[i]) sel_num = 2'(i);
      end
    end else if (|dw_hit) begin
      sel_cause = HBW_CAUSE_DWP;
      sel_thr = 8'(mem_thread);
      sel_info = mem_addr;
      for (int i = HBW_NBP - 1; i >= 0; i--) begin
        if (dw_hit[i]) sel_num = 2'(i);
      end
    end else if (|rw_hit) begin
      sel_cause = HBW_CAUSE_RWP;
      sel_thr = 8'(res_thread);
      sel_info = res_id;
      for (int i = HBW_NBP - 1; i >= 0; i--) begin
        if (rw_hit[i]) sel_num = 2'(i);
      end
    end else begin
      any_hit = 1'b0;
    end
  end

  // ***********************
  // event record
  // ***********************
  always_comb begin
    type_nxt = event_type_r;
    info_nxt = debug_event_info_r;
    if (ps_wr && ps_num == HBW_PS_EVT_TYPE) type_nxt = ps_wdata & HBW_TYPE_MASK;
    if (ps_wr && ps_num == HBW_PS_EVT_INFO) info_nxt = ps_wdata;
    // hardware capture wins over a same-cycle write
    if (any_hit) begin
      type_nxt = '0;
      type_nxt[HBW_CAUSE_HI:HBW_CAUSE_LO] = sel_cause;
      type_nxt[HBW_THRN_HI:HBW_THRN_LO] = sel_thr;
      type_nxt[HBW_NUM_HI:HBW_NUM_LO] = sel_num;
      info_nxt = sel_info;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_type_r <= '0;
      debug_event_info_r <= '0;
    end else begin
      event_type_r <= type_nxt;
      debug_event_info_r <= info_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      debug_irq <= 1'b0;
    end else begin
      debug_irq <= any_hit;
    end
  end

  // ***********************
  // thread stop mask
  // ***********************
  always_ff @(posedge clk) begin
    if (srst) begin
      thread_stop_mask_r <= '0;
    end else if (ps_wr && ps_num == HBW_PS_STOP) begin
      thread_stop_mask_r <= ps_wdata[7:0];
    end
  end

  // mask persists across debug return, so single steps stay halted
  assign thread_hold = debug_mode ? '0 : thread_stop_mask_r;

  // ***********************
  // breakpoint registers
  // ***********************
  generate
    for (g = 0; g < HBW_NBP; g++) begin : gr
      always_ff @(posedge clk) begin
        if (srst) begin
          instr_break_ctrl_r[g] <= HBW_CTRL_RST;
          data_watch_ctrl_r[g] <= HBW_CTRL_RST;
          resource_watch_ctrl_r[g] <= HBW_CTRL_RST;
        end else if (ps_wr && ps_sub == 2'(g)) begin
          if (ps_grp == HBW_PS_IBC[7:2]) instr_break_ctrl_r[g] <= ps_wdata & HBW_IBC_MASK;
          if (ps_grp == HBW_PS_DWC[7:2]) data_watch_ctrl_r[g] <= ps_wdata & HBW_DWC_MASK;
          if (ps_grp == HBW_PS_RWC[7:2]) resource_watch_ctrl_r[g] <= ps_wdata & HBW_RWC_MASK;
        end
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          instr_break_address_r[g] <= '0;
          data_watch_addr_first_r[g] <= '0;
          data_watch_addr_second_r[g] <= '0;
          resource_watch_mask_r[g] <= '0;
          resource_watch_value_r[g] <= '0;
        end else if (ps_wr && ps_sub == 2'(g)) begin
          if (ps_grp == HBW_PS_IBA[7:2]) instr_break_address_r[g] <= ps_wdata;
          if (ps_grp == HBW_PS_DWA1[7:2]) data_watch_addr_first_r[g] <= ps_wdata;
          if (ps_grp == HBW_PS_DWA2[7:2]) data_watch_addr_second_r[g] <= ps_wdata;
          if (ps_grp == HBW_PS_RWM[7:2]) resource_watch_mask_r[g] <= ps_wdata;
          if (ps_grp == HBW_PS_RWV[7:2]) resource_watch_value_r[g] <= ps_wdata;
        end
      end
    end
  endgenerate

  // ***********************
  // read paths
  // ***********************
  always_comb begin
    ps_rdata_nxt = '0;
    if (ps_num == HBW_PS_EVT_TYPE) ps_rdata_nxt = event_type_r;
    else if (ps_num == HBW_PS_EVT_INFO) ps_rdata_nxt = debug_event_info_r;
    else if (ps_num == HBW_PS_STOP) ps_rdata_nxt = 32'(thread_stop_mask_r) & HBW_STOP_MASK;
    else if (ps_num[7:3] == HBW_PS_SCR[7:3]) ps_rdata_nxt = scr.ps_rdata;
    else if (ps_grp == HBW_PS_IBA[7:2]) ps_rdata_nxt = instr_break_address_r[ps_sub];
    else if (ps_grp == HBW_PS_IBC[7:2]) ps_rdata_nxt = instr_break_ctrl_r[ps_sub];
    else if (ps_grp == HBW_PS_DWA1[7:2]) ps_rdata_nxt = data_watch_addr_first_r[ps_sub];
    else if (ps_grp == HBW_PS_DWA2[7:2]) ps_rdata_nxt = data_watch_addr_second_r[ps_sub];
    else if (ps_grp == HBW_PS_DWC[7:2]) ps_rdata_nxt = data_watch_ctrl_r[ps_sub];
    else if (ps_grp == HBW_PS_RWM[7:2]) ps_rdata_nxt = resource_watch_mask_r[ps_sub];
    else if (ps_grp == HBW_PS_RWV[7:2]) ps_rdata_nxt = resource_watch_value_r[ps_sub];
    else if (ps_grp == HBW_PS_RWC[7:2]) ps_rdata_nxt = resource_watch_ctrl_r[ps_sub];
  end

  always_comb begin
    tc_rdata_nxt = '0;
    if (tc_num[7:3] == HBW_TC_SCR[7:3]) tc_rdata_nxt = scr.tc_rdata;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ps_rdata <= '0;
    end else if (ps_rd) begin
      ps_rdata <= ps_rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tc_rdata <= '0;
    end else if (tc_rd) begin
      tc_rdata <= tc_rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ### src/hbw_pkg.sv
// Purpose: shared constants and types for the breakpoint and watchpoint unit
// Assumes: processor status register numbers are word indices
// Notes: tile configuration view only maps the scratch words
package hbw_pkg;
  localparam int HBW_NTHR = 8;
  localparam int HBW_NBP = 4;
  localparam int HBW_NSCR = 8;
  // processor status register numbers
  localparam logic [7:0] HBW_PS_EVT_TYPE = 8'h15;
  localparam logic [7:0] HBW_PS_EVT_INFO = 8'h16;
  localparam logic [7:0] HBW_PS_STOP = 8'h18;
  localparam logic [7:0] HBW_PS_SCR = 8'h20;
  localparam logic [7:0] HBW_PS_IBA = 8'h30;
  localparam logic [7:0] HBW_PS_IBC = 8'h40;
  localparam logic [7:0] HBW_PS_DWA1 = 8'h50;
  localparam logic [7:0] HBW_PS_DWA2 = 8'h60;
  localparam logic [7:0] HBW_PS_DWC = 8'h70;
  localparam logic [7:0] HBW_PS_RWM = 8'h80;
  localparam logic [7:0] HBW_PS_RWV = 8'h90;
  localparam logic [7:0] HBW_PS_RWC = 8'h9C;
  // tile configuration register numbers
  localparam logic [7:0] HBW_TC_SCR = 8'h20;
  // control fields
  localparam int HBW_EN_BIT = 0;
  localparam int HBW_COND_BIT = 1;
  localparam int HBW_LOAD_BIT = 2;
  localparam int HBW_THR_LO = 16;
  localparam int HBW_THR_HI = 23;
  localparam int HBW_CAUSE_LO = 0;
  localparam int HBW_CAUSE_HI = 2;
  localparam int HBW_THRN_LO = 8;
  localparam int HBW_THRN_HI = 15;
  localparam int HBW_NUM_LO = 16;
  localparam int HBW_NUM_HI = 17;
  localparam logic [2:0] HBW_CAUSE_IBP = 3'h3;
  localparam logic [2:0] HBW_CAUSE_DWP = 3'h4;
  localparam logic [2:0] HBW_CAUSE_RWP = 3'h5;
  localparam logic [31:0] HBW_CTRL_RST = 32'h0;
  localparam logic [31:0] HBW_IBC_MASK = 32'h00FF0003;
  localparam logic [31:0] HBW_DWC_MASK = 32'h00FF0007;
  localparam logic [31:0] HBW_RWC_MASK = 32'h00FF0003;
  localparam logic [31:0] HBW_STOP_MASK = 32'h000000FF;
  localparam logic [31:0] HBW_TYPE_MASK = 32'h0003FF07;
  typedef logic [31:0] hbw_word_t;
endpackage

// ### src/hbw_scr_if.sv
// Purpose: carrier between top and the scratch store
// Assumes: one write per port per cycle
// Notes: two access ports share one storage
`timescale 1ns/1ps
`default_nettype none
interface hbw_scr_if;
  logic ps_we;
  logic [2:0] ps_idx;
  logic [31:0] ps_wdata;
  logic [31:0] ps_rdata;
  logic tc_we;
  logic [2:0] tc_idx;
  logic [31:0] tc_wdata;
  logic [31:0] tc_rdata;
  modport owner(input ps_we, ps_idx, ps_wdata, tc_we, tc_idx, tc_wdata,
    output ps_rdata, tc_rdata);
  modport user(output ps_we, ps_idx, ps_wdata, tc_we, tc_idx, tc_wdata,
    input ps_rdata, tc_rdata);
endinterface
`default_nettype wire

// ### src/hbw_scratch.sv
// Purpose: eight debugger scratch words seen from two views
// Assumes: processor status write wins over a same-cycle tile write
// Notes: reads are combinational from the array
`timescale 1ns/1ps
`default_nettype none
module hbw_scratch
  import hbw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  hbw_scr_if.owner s
);
  logic [31:0] mem_r [HBW_NSCR];
  genvar g;
  generate
    for (g = 0; g < HBW_NSCR; g++) begin : gw
      always_ff @(posedge clk) begin
        if (srst) begin
          mem_r[g] <= '0;
        end else if (s.ps_we && s.ps_idx == 3'(g)) begin
          mem_r[g] <= s.ps_wdata;
        end else if (s.tc_we && s.tc_idx == 3'(g)) begin
          mem_r[g] <= s.tc_wdata;
        end
      end
    end
  endgenerate
  assign s.ps_rdata = mem_r[s.ps_idx];
  assign s.tc_rdata = mem_r[s.tc_idx];
endmodule
`default_nettype wire

// ### src/hbw_match.sv
// Purpose: one watch unit's trigger evaluation
// Assumes: all inputs are on clk
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hbw_match
  import hbw_pkg::*;
(
  input wire logic [31:0] ib_addr,
  input wire logic [31:0] ib_ctrl,
  input wire logic [31:0] dw_a1,
  input wire logic [31:0] dw_a2,
  input wire logic [31:0] dw_ctrl,
  input wire logic [31:0] rw_mask,
  input wire logic [31:0] rw_val,
  input wire logic [31:0] rw_ctrl,
  input wire logic [7:0] ib_thr,
  input wire logic [7:0] dw_thr,
  input wire logic [7:0] rw_thr,
  input wire logic pc_valid,
  input wire logic [31:0] pc,
  input wire logic mem_valid,
  input wire logic mem_load,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [31:0] res_id,
  output logic ib_hit,
  output logic dw_hit,
  output logic rw_hit
);
  logic ib_eq, dw_ca, dw_cb, rw_ca, rw_cb;
  assign ib_eq = (pc == ib_addr);
  assign ib_hit = pc_valid && ib_ctrl[HBW_EN_BIT]
    && ((ib_eq ^ ib_ctrl[HBW_COND_BIT]))
    && |(ib_thr & ib_ctrl[HBW_THR_HI:HBW_THR_LO]);
  assign dw_ca = (mem_addr == dw_a1);
  assign dw_cb = (mem_addr == dw_a2);
  assign dw_hit = mem_valid && dw_ctrl[HBW_EN_BIT]
    && (!mem_load || dw_ctrl[HBW_LOAD_BIT])
    && (dw_ctrl[HBW_COND_BIT] ? (dw_ca || dw_cb) : (dw_ca && dw_cb))
    && |(dw_thr & dw_ctrl[HBW_THR_HI:HBW_THR_LO]);
  // a: masked id equals value, b: masked id differs
  assign rw_ca = ((res_id & rw_mask) == rw_val);
  assign rw_cb = !rw_ca;
  assign rw_hit = res_valid && rw_ctrl[HBW_EN_BIT]
    && (rw_ctrl[HBW_COND_BIT] ? rw_cb : rw_ca)
    && |(rw_thr & rw_ctrl[HBW_THR_HI:HBW_THR_LO]);
endmodule
`default_nettype wire

// ### verif/hbw_unit_asserts.sv
// Purpose: port checks for the breakpoint unit
// Assumes: single clock, srst synchronous
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module hbw_unit_chk
  import hbw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ps_wr,
  input wire logic ps_rd,
  input wire logic [7:0] ps_num,
  input wire logic [31:0] ps_wdata,
  input wire logic [31:0] ps_rdata,
  input wire logic tc_rd,
  input wire logic [7:0] tc_num,
  input wire logic [31:0] tc_rdata,
  input wire logic debug_mode,
  input wire logic pc_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic debug_irq,
  input wire logic [7:0] thread_hold
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_hold_in_dbg: assert property (debug_mode |-> thread_hold == 8'h00)
    else $error("threads held in debug mode");
  a_hold_follows: assert property ((ps_wr && ps_num == HBW_PS_STOP) ##1 !debug_mode
    |-> {24'h0, thread_hold} == ($past(ps_wdata) & HBW_STOP_MASK)) else $error("hold mismatch");
  a_hold_steady: assert property (!debug_mode && !$past(debug_mode) && !$past(ps_wr)
    |-> $stable(thread_hold)) else $error("hold changed");
  a_irq_cause: assert property (debug_irq |-> $past(pc_valid) || $past(mem_valid)
    || $past(res_valid)) else $error("irq without event");
  a_irq_dbg_quiet: assert property (debug_mode |=> !debug_irq)
    else $error("irq in debug mode");
  a_tc_unmapped: assert property (tc_rd && (tc_num < 8'h20 || tc_num > 8'h27)
    |=> tc_rdata == 32'h0) else $error("unmapped tile read");
  a_type_rsvd: assert property (ps_rd && ps_num == HBW_PS_EVT_TYPE
    |=> (ps_rdata & ~HBW_TYPE_MASK) == 32'h0 && ps_rdata[2:0] inside {3'h0, 3'h3, 3'h4, 3'h5})
    else $error("bad type read");
  a_stop_rsvd: assert property (ps_rd && ps_num == HBW_PS_STOP |=> ps_rdata[31:8] == 24'h0)
    else $error("stop reserved bits");
  a_rdata_holds: assert property (!ps_rd |=> $stable(ps_rdata))
    else $error("read data moved");
endmodule
bind hbw_unit hbw_unit_chk chk_u (.*);
`default_nettype wire

// ### verif/hbw_core_model.sv
// Purpose: core and debug software stand-in
// Assumes: events one cycle each
// Notes: enters debug on irq, leaves on dret
`timescale 1ns/1ps
`default_nettype none
module hbw_core_model
  import hbw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic debug_irq,
  input wire logic dret,
  output logic debug_mode,
  output logic pc_valid,
  output logic [2:0] pc_thread,
  output logic [31:0] pc,
  output logic mem_valid,
  output logic mem_load,
  output logic [2:0] mem_thread,
  output logic [31:0] mem_addr,
  output logic res_valid,
  output logic [2:0] res_thread,
  output logic [31:0] res_id
);
  initial begin
    debug_mode = 1'b0;
    {pc_valid, mem_valid, res_valid, mem_load} = 4'h0;
    {pc_thread, mem_thread, res_thread} = 9'h0;
    {pc, mem_addr, res_id} = 96'h0;
  end
  always @(posedge clk) begin
    if (srst || dret)
      debug_mode <= 1'b0;
    else if (debug_irq)
      debug_mode <= 1'b1;
  end
  task automatic issue(input logic [2:0] k, input logic [2:0] t, input hbw_word_t v,
    input logic ld);
    @(posedge clk);
    {res_valid, mem_valid, pc_valid} <= k;
    // pc thread differs unless pc is issued; mem and res threads always take t
    pc_thread <= k[0] ? t : ~t;
    {mem_thread, res_thread} <= {t, t};
    {pc, mem_addr, res_id} <= {v, v, v};
    mem_load <= ld;
    @(posedge clk);
    {res_valid, mem_valid, pc_valid} <= 3'h0;
    {pc, mem_addr, res_id} <= {~v, ~v, ~v};
  endtask
endmodule
`default_nettype wire

// ### verif/hbw_unit_test.sv
// Purpose: register and trigger tests of the unit
// Assumes: events come from the core model
// Notes: reads compare one cycle after strobe
`timescale 1ns/1ps
`default_nettype none
module hbw_unit_test
  import hbw_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ps_wr = 1'b0, ps_rd = 1'b0, tc_wr = 1'b0, tc_rd = 1'b0, dret = 1'b0;
  logic [7:0] ps_num = 8'h0, tc_num = 8'h0;
  hbw_word_t ps_wdata = 32'h0, tc_wdata = 32'h0;
  wire hbw_word_t ps_rdata, tc_rdata, pc, mem_addr, res_id;
  wire logic debug_mode, pc_valid, mem_valid, mem_load, res_valid, debug_irq;
  wire logic [2:0] pc_thread, mem_thread, res_thread;
  wire logic [7:0] thread_hold;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] cn [4] = '{8'h41, 8'h72, 8'h9F, 8'h18};
  hbw_word_t cm [4] = '{HBW_IBC_MASK, HBW_DWC_MASK, HBW_RWC_MASK, HBW_STOP_MASK};
  always #50 clk = ~clk;
  hbw_unit dut_u (.clk(clk), .srst(srst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_num(ps_num),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .tc_wr(tc_wr), .tc_rd(tc_rd), .tc_num(tc_num),
    .tc_wdata(tc_wdata), .tc_rdata(tc_rdata), .debug_mode(debug_mode), .pc_valid(pc_valid),
    .pc_thread(pc_thread), .pc(pc), .mem_valid(mem_valid), .mem_load(mem_load),
    .mem_thread(mem_thread), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_thread(res_thread), .res_id(res_id), .debug_irq(debug_irq), .thread_hold(thread_hold));
  hbw_core_model part_u (.clk(clk), .srst(srst), .debug_irq(debug_irq), .dret(dret),
    .debug_mode(debug_mode), .pc_valid(pc_valid), .pc_thread(pc_thread), .pc(pc),
    .mem_valid(mem_valid), .mem_load(mem_load), .mem_thread(mem_thread), .mem_addr(mem_addr),
    .res_valid(res_valid), .res_thread(res_thread), .res_id(res_id));
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input hbw_word_t s, input hbw_word_t e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // tc selects the tile view; a read compares against d
  task automatic acc(input bit tc, input bit wr, input logic [7:0] n, input hbw_word_t d);
    @(posedge clk);
    if (tc) begin
      {tc_wr, tc_rd, tc_num, tc_wdata} <= {wr, !wr, n, d};
    end else begin
      {ps_wr, ps_rd, ps_num, ps_wdata} <= {wr, !wr, n, d};
    end
    @(posedge clk);
    {ps_wr, ps_rd, tc_wr, tc_rd} <= 4'h0;
    #1;
    if (!wr)
      chk(tc ? tc_rdata : ps_rdata, d);
  endtask
  task automatic fire(input logic [2:0] k, input logic [2:0] t, input hbw_word_t v,
    input logic ld, input logic e);
    part_u.issue(k, t, v, ld);
    #1;
    chk({31'h0, debug_irq}, {31'h0, e});
  endtask
  task automatic leave;
    @(posedge clk);
    dret <= 1'b1;
    @(posedge clk);
    dret <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (cn[i]) begin
      acc(0, 0, cn[i], 32'h0);
      acc(0, 1, cn[i], 32'hFFFFFFFF);
      acc(0, 0, cn[i], cm[i]);
      acc(0, 1, cn[i], 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      acc(0, 1, 8'h20 + 8'(i), 32'hC0DE0000 + 32'(i));
      acc(1, 0, 8'h20 + 8'(i), 32'hC0DE0000 + 32'(i));
    end
    acc(1, 1, 8'h27, 32'h5A5AA5A5);
    acc(0, 0, 8'h27, 32'h5A5AA5A5);
    acc(1, 0, 8'h05, 32'h0);
    acc(0, 1, 8'h18, 32'hA5);
    acc(0, 1, 8'h31, 32'h1000);
    acc(0, 1, 8'h32, 32'h1000);
    acc(0, 1, 8'h41, 32'h00040001);
    acc(0, 1, 8'h42, 32'h00040001);
    fire(3'h1, 3'h3, 32'h1000, 1'b0, 1'b0);
    fire(3'h7, 3'h2, 32'h1000, 1'b0, 1'b1);
    acc(0, 0, 8'h15, 32'h00010203);
    chk({24'h0, thread_hold}, 32'h0);
    leave;
    chk({24'h0, thread_hold}, 32'hA5);
    acc(0, 1, 8'h41, 32'h00040003);
    fire(3'h1, 3'h2, 32'h2000, 1'b0, 1'b1);
    // core is now in debug mode: the same event must be ignored
    fire(3'h1, 3'h2, 32'h2000, 1'b0, 1'b0);
    leave;
    acc(0, 1, 8'h41, 32'h0);
    acc(0, 1, 8'h42, 32'h0);
    acc(0, 1, 8'h50, 32'h4000);
    acc(0, 1, 8'h60, 32'h4008);
    acc(0, 1, 8'h70, 32'h00010003);
    fire(3'h2, 3'h0, 32'h4000, 1'b1, 1'b0);
    fire(3'h2, 3'h0, 32'h4008, 1'b0, 1'b1);
    acc(0, 0, 8'h16, 32'h4008);
    acc(0, 0, 8'h15, 32'h00000004);
    leave;
    acc(0, 1, 8'h70, 32'h00010005);
    fire(3'h2, 3'h0, 32'h4008, 1'b1, 1'b0);
    acc(0, 1, 8'h60, 32'h4000);
    fire(3'h2, 3'h0, 32'h4000, 1'b1, 1'b1);
    leave;
    acc(0, 1, 8'h70, 32'h00010004);
    fire(3'h2, 3'h0, 32'h4000, 1'b1, 1'b0);
    acc(0, 1, 8'h83, 32'hFF);
    acc(0, 1, 8'h93, 32'h42);
    acc(0, 1, 8'h9F, 32'h00800001);
    fire(3'h4, 3'h7, 32'h1242, 1'b0, 1'b1);
    acc(0, 0, 8'h16, 32'h1242);
    acc(0, 0, 8'h15, 32'h00030705);
    leave;
    acc(0, 1, 8'h9F, 32'h00800003);
    fire(3'h4, 3'h7, 32'h1242, 1'b0, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
